// file: core/cbs_params.svh
// timing counts, register offsets and field positions of the control bus
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH
`define CBS_CLK_PERIOD_NS      20
`define CBS_FAST_CLEAR_IN_RECOVER_NS    600
`define CBS_FAST_CLEAR_IN_RECOVER_CYC   \
  ((`CBS_FAST_CLEAR_IN_RECOVER_NS + `CBS_CLK_PERIOD_NS - 1) / `CBS_CLK_PERIOD_NS)
`define CBS_CONFIG_LED_NS      10000
`define CBS_CONFIG_LED_CYC     (`CBS_CONFIG_LED_NS / `CBS_CLK_PERIOD_NS)
`define CBS_ACK_LED_NS         1000
`define CBS_ACK_LED_CYC        (`CBS_ACK_LED_NS / `CBS_CLK_PERIOD_NS)
`define CBS_OFS_STATUS1        12'h000
`define CBS_OFS_CONTROL1       12'h004
`define CBS_OFS_FCWINDOW       12'h008
`define CBS_OFS_BASEADDR       12'h00C
`define CBS_BIT_DATA_READY_BUS_OR           0
`define CBS_BIT_DATA_READY_BUS_OR_BUS       1
`define CBS_BIT_BUSY           2
`define CBS_BIT_BUSY_BUS       3
`define CBS_BIT_RESET_SCOPE    4
`define CBS_FCWINDOW_RESET     10'h020
`define CBS_RESP_OKAY          2'h0
`define CBS_RESP_SLVERR        2'h2
`define CBS_TERM_LINES         7
`endif

// file: core/cbs_pkg.sv
// types shared by the control bus and status logic
package cbs_pkg;
  typedef enum logic [1:0] {
    CBS_IDLE  = 2'h0,
    CBS_INTEG = 2'h1,
    CBS_CONV  = 2'h3,
    CBS_CLEAR = 2'h2
  } cbs_state_t;

  typedef struct packed {
    logic busyBusOr;
    logic busy;
    logic dataReadyBusOr;
    logic dataReady;
  } cbs_status_t;

  typedef struct packed {
    logic ack;
    logic busy;
    logic dataReady;
    logic termGreen;
    logic termRed;
  } cbs_leds_t;
endpackage

// file: core/cbs_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module cbs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // cbs_sync

// file: core/cbs_stretch.sv
// pulse stretcher that keeps an indicator lit for a fixed count
`timescale 1ns/1ps
module cbs_stretch #(
  parameter int          COUNT    = 50,
  parameter bit          RESET_ON = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic trigger,
  output logic      lit
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LOAD = CW'(COUNT);
  logic [CW-1:0] count_q;

  if (COUNT < 1) begin : g_chk
    $error("cbs_stretch: COUNT must be at least 1");
  end

  // power-on variant starts loaded so the indicator shows configuration
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= RESET_ON ? LOAD : '0;
    end else if (trigger) begin
      count_q <= LOAD;
    end else if (count_q != '0) begin
      count_q <= count_q - CW'(1);
    end
  end

  assign lit = (count_q != '0);
endmodule // cbs_stretch

// file: core/cbs_control_bus.sv
// front-panel control inputs, wired-OR bus lines, status registers, LEDs
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "cbs_params.svh"
module cbs_control_bus
  import cbs_pkg::*;
#(
  parameter int FCW_WIDTH = 10,
  parameter bit DUAL_GATE = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // front-panel pins
  input  wire logic        gateIn,
  input  wire logic        aux_gate_in,
  input  wire logic        fast_clear_in,
  input  wire logic        frontResetIn,
  input  wire logic        conversion_inhibit,
  input  wire logic        data_ready_bus_or,
  input  wire logic        busyBusOrIn,
  output logic             dataReadyLineOut,
  output logic             dataReadyLineOe,
  output logic             busyLineOut,
  output logic             busyLineOe,
  // board straps and switches
  input  wire logic        busy_policy_jumper,
  input  wire logic [15:0] rotarySwitch,
  input  wire logic [13:0] termSwitch,
  // converter datapath, same clock
  input  wire logic        bufferNotEmpty,
  input  wire logic        bufferFull,
  input  wire logic        memTestMode,
  input  wire logic        conversionDone,
  input  wire logic [4:0]  convChannel,
  output logic             startConversion,
  output logic             abortConversion,
  output logic             clearIntegrators,
  output logic             dataResetPulse,
  output logic             softResetPulse,
  output logic             inputBlockSel,
  output logic [15:0]      baseAddress,
  output cbs_leds_t        leds
);
  // ************************************************************
  // constants and checks
  // ************************************************************
  localparam logic [4:0] RECOVER = 5'(`CBS_FAST_CLEAR_IN_RECOVER_CYC);

  if (FCW_WIDTH < 1 || FCW_WIDTH > 16) begin : g_chk
    $error("cbs_control_bus: FCW_WIDTH must be 1 to 16");
  end

  function automatic logic chanBlock(input logic [4:0] ch);
    return ch[4];
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [22:0] pinSync;
  logic [15:0] rotarySync;
  logic [13:0] termSync;

  cbs_sync #(.WIDTH(7)) u_syncPins (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({gateIn, aux_gate_in, fast_clear_in, frontResetIn,
               conversion_inhibit, data_ready_bus_or, busyBusOrIn}),
    .syncOut (pinSync[6:0])
  );
  cbs_sync #(.WIDTH(30)) u_syncStatic (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({busy_policy_jumper, rotarySwitch, termSwitch[12:0]}),
    .syncOut ({pinSync[7], rotarySync, termSync[12:0]})
  );
  cbs_sync #(.WIDTH(1)) u_syncTerm13 (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (termSwitch[13]),
    .syncOut (termSync[13])
  );
  assign pinSync[22:8] = '0;

  logic gateS, auxGateS, fclrS, rstS, vetoS, drBusS, busyBusS, policyS;
  assign {gateS, auxGateS, fclrS, rstS, vetoS, drBusS, busyBusS} =
         pinSync[6:0];
  assign policyS = pinSync[7];

  // ************************************************************
  // edge detection
  // ************************************************************
  logic gateComb;
  logic gate_q, fast_clear_in_q, rst_q;
  logic gateRise, gateFall, fclrRise, resetEdge;

  assign gateComb = gateS | (DUAL_GATE & auxGateS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_q <= 1'b0;
      fast_clear_in_q <= 1'b0;
      rst_q  <= 1'b0;
    end else begin
      gate_q <= gateComb;
      fast_clear_in_q <= fclrS;
      rst_q  <= rstS;
    end
  end

  assign gateRise  = gateComb & ~gate_q;
  assign gateFall  = ~gateComb & gate_q;
  assign fclrRise  = fclrS & ~fast_clear_in_q;
  assign resetEdge = rstS & ~rst_q;

  // ************************************************************
  // registers written by software
  // ************************************************************
  logic                 resetScope_q;
  logic [FCW_WIDTH-1:0] fcWindow_q;
  logic                 softReset;

  assign softReset = resetEdge & resetScope_q;

  // ************************************************************
  // acquisition sequence
  // ************************************************************
  cbs_state_t           state_q;
  logic [FCW_WIDTH-1:0] fcwCnt_q;
  logic [4:0]           clrCnt_q;
  logic                 fcwOpen, fclrAccept, ownBusy, stopAcq;

  // window: gate leading edge through the whole gate, then in conversion until the programmed count expires
  assign fcwOpen    = (state_q == CBS_INTEG) ||
                      (state_q == CBS_CONV && fcwCnt_q != '0);
  assign fclrAccept = fclrRise & fcwOpen;
  assign ownBusy    = (state_q != CBS_IDLE) | memTestMode | bufferFull;
  assign stopAcq    = policyS ? (ownBusy | busyBusS) : ownBusy;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= CBS_IDLE;
      clrCnt_q <= '0;
    end else if (resetEdge) begin
      state_q  <= CBS_CLEAR;
      clrCnt_q <= RECOVER;
    end else begin
      unique case (state_q)
        CBS_IDLE: begin
          if (gateRise && !stopAcq) begin
            state_q <= CBS_INTEG;
          end
        end
        CBS_INTEG: begin
          if (fclrAccept) begin
            state_q  <= CBS_CLEAR;
            clrCnt_q <= RECOVER;
          end else if (gateFall && vetoS) begin
            state_q  <= CBS_CLEAR;
            clrCnt_q <= RECOVER;
          end else if (gateFall) begin
            state_q <= CBS_CONV;
          end
        end
        CBS_CONV: begin
          if (fclrAccept) begin
            state_q  <= CBS_CLEAR;
            clrCnt_q <= RECOVER;
          end else if (conversionDone) begin
            state_q <= CBS_IDLE;
          end
        end
        CBS_CLEAR: begin
          if (clrCnt_q <= 5'h01) begin
            state_q  <= CBS_IDLE;
            clrCnt_q <= '0;
          end else begin
            clrCnt_q <= clrCnt_q - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fcwCnt_q <= '0;
    end else if (state_q == CBS_IDLE && gateRise && !stopAcq) begin
      fcwCnt_q <= fcWindow_q;
    end else if (fcwCnt_q != '0) begin
      fcwCnt_q <= fcwCnt_q - FCW_WIDTH'(1);
    end
  end

  // one-cycle commands to the converter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      startConversion  <= 1'b0;
      abortConversion  <= 1'b0;
      clearIntegrators <= 1'b0;
      dataResetPulse   <= 1'b0;
      softResetPulse   <= 1'b0;
    end else begin
      startConversion  <= (state_q == CBS_INTEG) & gateFall & ~vetoS &
                          ~fclrAccept & ~resetEdge;
      abortConversion  <= fclrAccept | resetEdge;
      clearIntegrators <= fclrAccept | resetEdge;
      dataResetPulse   <= resetEdge;
      softResetPulse   <= softReset;
    end
  end

  // ************************************************************
  // wired-or bus lines and status
  // ************************************************************
  logic dataReady_q, busy_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataReady_q <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      dataReady_q <= bufferNotEmpty;
      busy_q      <= ownBusy;
    end
  end

  // drive only a high level so that several modules can share a line
  assign dataReadyLineOut = 1'b1;
  assign dataReadyLineOe  = dataReady_q;
  assign busyLineOut      = 1'b1;
  assign busyLineOe       = busy_q;

  cbs_status_t status1;
  assign status1.dataReady      = dataReady_q;
  assign status1.dataReadyBusOr = drBusS;
  assign status1.busy           = busy_q;
  assign status1.busyBusOr      = busyBusS;

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic        awHeld_q, wHeld_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q;
  logic        wrFire, rdFire;

  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wrFire = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign rdFire = s_axi_arvalid & s_axi_arready;

  function automatic logic mapped(input logic [11:0] a);
    return a == `CBS_OFS_STATUS1 || a == `CBS_OFS_CONTROL1 ||
           a == `CBS_OFS_FCWINDOW || a == `CBS_OFS_BASEADDR;
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q     <= 1'b0;
      wHeld_q      <= 1'b0;
      awAddr_q     <= '0;
      wData_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CBS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
      end
      if (wrFire) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_q) ? `CBS_RESP_OKAY
                                         : `CBS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // wstrb[0] alone gates writes, though fcWindow_q bits 8 and up sit in byte lane 1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resetScope_q <= 1'b0;
      fcWindow_q   <= FCW_WIDTH'(`CBS_FCWINDOW_RESET);
    end else if (softReset) begin
      resetScope_q <= 1'b0;
      fcWindow_q   <= FCW_WIDTH'(`CBS_FCWINDOW_RESET);
    end else if (wrFire && s_axi_wstrb[0]) begin
      if (awAddr_q == `CBS_OFS_CONTROL1) begin
        resetScope_q <= wData_q[`CBS_BIT_RESET_SCOPE];
      end
      if (awAddr_q == `CBS_OFS_FCWINDOW) begin
        fcWindow_q <= wData_q[FCW_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `CBS_RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped({s_axi_araddr[11:2], 2'h0}) ?
                      `CBS_RESP_OKAY : `CBS_RESP_SLVERR;
      unique case ({s_axi_araddr[11:2], 2'h0})
        `CBS_OFS_STATUS1:  s_axi_rdata <= {28'h0000000, status1};
        `CBS_OFS_CONTROL1: s_axi_rdata <= 32'(resetScope_q)
                                          << `CBS_BIT_RESET_SCOPE;
        `CBS_OFS_FCWINDOW: s_axi_rdata <= 32'(fcWindow_q);
        `CBS_OFS_BASEADDR: s_axi_rdata <= {16'h0000, baseAddress};
        default:           s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // address, channel block and indicators
  // ************************************************************
  logic [`CBS_TERM_LINES-1:0] lineTerm;
  logic ackLit, configLit;

  always_comb begin
    for (int i = 0; i < `CBS_TERM_LINES; i++) begin
      lineTerm[i] = termSync[2*i] & termSync[2*i+1];
    end
  end

  cbs_stretch #(.COUNT(`CBS_ACK_LED_CYC), .RESET_ON(1'b0)) u_ackLed (
    .clk     (clk),
    .reset_n (reset_n),
    .trigger (wrFire | rdFire),
    .lit     (ackLit)
  );
  cbs_stretch #(.COUNT(`CBS_CONFIG_LED_CYC), .RESET_ON(1'b1)) u_cfgLed (
    .clk     (clk),
    .reset_n (reset_n),
    .trigger (1'b0),
    .lit     (configLit)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      baseAddress   <= '0;
      inputBlockSel <= 1'b0;
      leds          <= '0;
    end else begin
      baseAddress   <= rotarySync;
      inputBlockSel <= chanBlock(convChannel);
      leds.ack       <= ackLit;
      leds.busy      <= ownBusy | configLit;
      leds.dataReady <= bufferNotEmpty | configLit;
      // both colours together show orange while configuring
      leds.termGreen <= configLit | (&lineTerm);
      leds.termRed   <= configLit | ~(|lineTerm);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence fclrSteps;
    fclrAccept && !resetEdge ##1 clearIntegrators && abortConversion
    ##0 state_q == CBS_CLEAR;
  endsequence

  AST_FAST_CLEAR_IN_ACCEPT: assert property (fclrAccept |-> fclrSteps)
    else $error("fast clear did not clear and abort");
  AST_FAST_CLEAR_IN_OUTSIDE: assert property (
    fclrRise && !fcwOpen && !resetEdge |=> !clearIntegrators)
    else $error("fast clear acted outside its window");
  AST_RESET_DATA: assert property (
    resetEdge |=> dataResetPulse && clearIntegrators &&
                  abortConversion && state_q == CBS_CLEAR)
    else $error("front reset incomplete");
  AST_RESET_SCOPE: assert property (
    resetEdge |=> softResetPulse == $past(resetScope_q))
    else $error("reset scope not honoured");
  AST_SOFT_CLEARS: assert property (
    softReset |=> !resetScope_q)
    else $error("software reset left control bit set");
  AST_BUSY_LINE: assert property (
    state_q != CBS_IDLE |=> busyLineOe && status1.busy)
    else $error("busy not shown while sequencing");
  AST_DATA_READY_BUS_OR_LINE: assert property (
    bufferNotEmpty ##1 bufferNotEmpty |-> dataReadyLineOe)
    else $error("data ready line not driven");
  AST_CONVERSION_INHIBIT: assert property (
    state_q == CBS_INTEG && gateFall && vetoS |=> !startConversion)
    else $error("conversion started under inhibit");
  AST_GATE_BUSY: assert property (
    state_q == CBS_CONV && !fclrAccept && !resetEdge && !conversionDone
    |=> state_q == CBS_CONV)
    else $error("gate accepted while converting");
endmodule // cbs_control_bus

// file: tb/cbs_far_end.sv
// far-end model: trigger electronics and other modules on the control bus
`timescale 1ns/1ps
module cbs_far_end (
  input  wire logic       clk,
  input  wire logic       drdyOe,
  input  wire logic       drdyOut,
  input  wire logic       busyOe,
  input  wire logic       busyOut,
  input  wire logic       otherDrdy,
  input  wire logic       otherBusy,
  output logic            drdyBus,
  output logic            busyBus,
  output logic      [4:0] pins
);
  // ****************************************
  // pins: 0 gate, 1 aux gate, 2 fast clear, 3 front reset, 4 inhibit
  // ****************************************
  logic [4:0] pinQ = 5'h00;

  assign pins = pinQ;
  // wired or: nobody ever pulls a line inactive, so any module wins
  assign drdyBus = (drdyOe & drdyOut) | otherDrdy;
  assign busyBus = (busyOe & busyOut) | otherBusy;

  task automatic set_pin(input int sel, input logic val);
    @(posedge clk);
    pinQ[sel] <= val;
  endtask

  // len of at least two cycles keeps the minimum pulse width
  task automatic pulse(input int sel, input int len);
    set_pin(sel, 1'b1);
    repeat (len) @(posedge clk);
    pinQ[sel] <= 1'b0;
  endtask
endmodule // cbs_far_end

// file: tb/test_control_bus_status_logic.sv
// self-checking bench for the control bus and status logic
`timescale 1ns/1ps
`include "cbs_params.svh"
module test_control_bus_status_logic
  import cbs_pkg::*;
;
  logic        clk = 1'b0, reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, rnd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        otherDrdy = 1'b0, otherBusy = 1'b0, drdyBus, busyBus;
  logic [4:0]  pins, convChannel = 5'h00;
  logic        dataReadyLineOut, dataReadyLineOe, busyLineOut, busyLineOe;
  logic        busy_policy_jumper = 1'b0, bufferNotEmpty = 1'b0;
  logic        bufferFull = 1'b0, memTestMode = 1'b0, conversionDone = 1'b0;
  logic [15:0] rotarySwitch = 16'h0000, baseAddress;
  logic [13:0] termSwitch = 14'h3FFF;
  logic [13:0] terms [3] = '{14'h3FFF, 14'h0000, 14'h0D03};
  logic        startConversion, abortConversion, clearIntegrators;
  logic        dataResetPulse, softResetPulse, inputBlockSel;
  cbs_leds_t   leds;
  int error_cnt = 0, samples_checked = 0, cyc = 0, s0, s1;
  int nStart = 0, nClr = 0, nAbort = 0, nData = 0, nSoft = 0;

  always #10 clk = ~clk;

  cbs_control_bus #(.FCW_WIDTH(10), .DUAL_GATE(1'b1)) i_dut (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .gateIn(pins[0]),
    .aux_gate_in(pins[1]), .fast_clear_in(pins[2]),
    .frontResetIn(pins[3]), .conversion_inhibit(pins[4]),
    .data_ready_bus_or(drdyBus), .busyBusOrIn(busyBus),
    .dataReadyLineOut, .dataReadyLineOe, .busyLineOut, .busyLineOe,
    .busy_policy_jumper, .rotarySwitch, .termSwitch, .bufferNotEmpty,
    .bufferFull, .memTestMode, .conversionDone, .convChannel,
    .startConversion, .abortConversion, .clearIntegrators,
    .dataResetPulse, .softResetPulse, .inputBlockSel, .baseAddress, .leds);

  cbs_far_end i_far (
    .clk, .drdyOe(dataReadyLineOe), .drdyOut(dataReadyLineOut),
    .busyOe(busyLineOe), .busyOut(busyLineOut), .otherDrdy, .otherBusy,
    .drdyBus, .busyBus, .pins);

  // ****************************************
  // pulse counters and hang guard
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (startConversion === 1'b1) nStart++;
    if (clearIntegrators === 1'b1) nClr++;
    if (abortConversion === 1'b1) nAbort++;
    if (dataResetPulse === 1'b1) nData++;
    if (softResetPulse === 1'b1) nSoft++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // gate pulse on one pin, then count conversions that it started
  task automatic gate_try(input int sel, input int exp);
    s0 = nStart;
    i_far.pulse(sel, 6);
    repeat (12) @(posedge clk);
    chk("starts", nStart - s0, exp);
  endtask

  task automatic conv_done();
    conversionDone <= 1'b1;
    @(posedge clk);
    conversionDone <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [3:0] exp_status(input logic ne, fu, mt, od, ob);
    logic bz;
    bz = fu | mt;
    return {bz | ob, bz, ne | od, ne};
  endfunction

  function automatic logic [1:0] exp_term(input logic [13:0] t);
    int n;
    n = 0;
    for (int i = 0; i < `CBS_TERM_LINES; i++) n += int'(t[2*i] & t[2*i+1]);
    return {n == `CBS_TERM_LINES, n == 0};
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(42));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("cfgLeds", leds[3:0], 4'hF);
    repeat (520) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      rnd = $urandom;
      bufferNotEmpty <= rnd[0];
      bufferFull <= rnd[1];
      memTestMode <= rnd[2] & rnd[3];
      otherDrdy <= rnd[4];
      otherBusy <= rnd[5];
      convChannel <= rnd[10:6];
      rotarySwitch <= rnd[31:16];
      repeat (8) @(posedge clk);
      rd_reg(`CBS_OFS_STATUS1);
      chk("status1", rd[3:0],
          exp_status(rnd[0], rnd[1], rnd[2] & rnd[3], rnd[4], rnd[5]));
      chk("busyOe", busyLineOe, rnd[1] | (rnd[2] & rnd[3]));
      chk("drdyOe", dataReadyLineOe, rnd[0]);
      chk("busyLed", leds.busy, rnd[1] | (rnd[2] & rnd[3]));
      chk("drdyLed", leds.dataReady, rnd[0]);
      chk("ackLed", leds.ack, 1'b1);
      chk("blockSel", inputBlockSel, rnd[10]);
      chk("basePort", baseAddress, rnd[31:16]);
      rd_reg(`CBS_OFS_BASEADDR);
      chk("baseReg", rd, {16'h0000, rnd[31:16]});
    end
    bufferNotEmpty <= 1'b0;
    bufferFull <= 1'b0;
    memTestMode <= 1'b0;
    otherDrdy <= 1'b0;
    otherBusy <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      termSwitch <= terms[i];
      repeat (8) @(posedge clk);
      chk("term", {leds.termGreen, leds.termRed}, exp_term(terms[i]));
    end
    gate_try(0, 1);
    chk("busyConv", busyLineOe, 1'b1);
    gate_try(1, 0);
    conv_done();
    chk("busyDone", busyLineOe, 1'b0);
    gate_try(1, 1);
    conv_done();
    i_far.set_pin(4, 1'b1);
    gate_try(0, 0);
    i_far.set_pin(4, 1'b0);
    repeat (40) @(posedge clk);
    // a busy neighbour only blocks when the jumper selects the global busy
    busy_policy_jumper <= 1'b1;
    otherBusy <= 1'b1;
    repeat (8) @(posedge clk);
    gate_try(0, 0);
    busy_policy_jumper <= 1'b0;
    gate_try(0, 1);
    conv_done();
    otherBusy <= 1'b0;
    s0 = nClr;
    i_far.pulse(2, 4);
    repeat (10) @(posedge clk);
    chk("fcIdle", nClr - s0, 0);
    s1 = nAbort;
    i_far.set_pin(0, 1'b1);
    repeat (6) @(posedge clk);
    i_far.pulse(2, 4);
    repeat (6) @(posedge clk);
    chk("fcClear", nClr - s0, 1);
    chk("fcAbort", nAbort - s1, 1);
    s0 = nStart;
    i_far.set_pin(0, 1'b0);
    repeat (40) @(posedge clk);
    chk("fcNoStart", nStart - s0, 0);
    wr(`CBS_OFS_FCWINDOW, 32'h0000_0055);
    gate_try(0, 1);
    s0 = nData;
    s1 = nSoft;
    i_far.pulse(3, 4);
    repeat (45) @(posedge clk);
    chk("dataRst", nData - s0, 1);
    chk("rstStops", busyLineOe, 1'b0);
    chk("noSoft", nSoft - s1, 0);
    rd_reg(`CBS_OFS_FCWINDOW);
    chk("fcwKept", rd, 32'h0000_0055);
    wr(`CBS_OFS_CONTROL1, 32'h0000_0010);
    i_far.pulse(3, 4);
    repeat (45) @(posedge clk);
    chk("softRst", nSoft - s1, 1);
    rd_reg(`CBS_OFS_FCWINDOW);
    chk("fcwReset", rd, {22'h0, `CBS_FCWINDOW_RESET});
    rd_reg(`CBS_OFS_CONTROL1);
    chk("scopeClr", rd[`CBS_BIT_RESET_SCOPE], 1'b0);
    wr(12'h0F0, 32'hFFFF_FFFF);
    chk("unmapWr", rs, `CBS_RESP_SLVERR);
    rd_reg(12'h0F0);
    chk("unmapRd", {rs, rd[29:0]}, {`CBS_RESP_SLVERR, 30'h0});
    close_out();
  end
endmodule // test_control_bus_status_logic
